// [fswdt_core.sv]
// Overview of operation
// - Application reset leaves watchdog enabled and counting.
// - Disable stops, enable restarts, accepted any time until the reset request fires.
// - Overflow raises prewarning first, reset request after.
// - Sixteen-bit counter ticks at clock/16384 or /256.
// - Counter loads from programmable reload value.
// - Service reloads counter and clears prescaler together.
// - Reset defaults give 6.5 ms at 10 MHz.
`timescale 1ns/1ns
`include "fswdt_map.svh"

module fswdt_core #(
	parameter int INTERVAL_CYCLES = `FSWDT_INTERVAL_CYCLES
) (
	input  wire logic                         core_clk,
	input  wire logic                         sys_rst,
	input  wire logic                         service_instr,
	input  wire logic                         watchdog_disable_instruction,
	input  wire logic                         watchdog_enable_instruction,
	input  wire logic                         reload_write,
	input  wire logic [`FSWDT_CNT_WIDTH-1:0]  reload_write_data,
	input  wire logic                         prescale_write_sel,
	output logic                              prewarn_irq,
	output logic                              reset_req,
	output logic                              wdt_running,
	output logic [`FSWDT_CNT_WIDTH-1:0]       wdt_count
);

	////////////////////////////////////////////////////////////////////////////////
	// Default reload value.
	////////////////////////////////////////////////////////////////////////////////

	// Ticks of the short ratio needed to cover the default interval, rounded up.
	localparam int DEFAULT_TICKS =
		(INTERVAL_CYCLES + `FSWDT_RATIO_SHORT - 1) / `FSWDT_RATIO_SHORT;
	// Reload that leaves exactly that many ticks before the wrap.
	localparam logic [`FSWDT_CNT_WIDTH-1:0] RELOAD_DEFAULT =
		`FSWDT_CNT_WIDTH'(`FSWDT_CNT_SPAN - DEFAULT_TICKS);

	////////////////////////////////////////////////////////////////////////////////
	// Helper function.
	////////////////////////////////////////////////////////////////////////////////

	// Returns the last prescaler value before a tick for the chosen ratio.
	function automatic logic [`FSWDT_PRE_WIDTH-1:0] fswdt_pre_last(input logic sel);
		logic [`FSWDT_PRE_WIDTH-1:0] last;
		last = 14'h3FFF;
		if (sel == `FSWDT_SEL_SHORT) begin
			last = `FSWDT_PRE_WIDTH'(`FSWDT_RATIO_SHORT - 1);
		end else begin
			last = `FSWDT_PRE_WIDTH'(`FSWDT_RATIO_LONG - 1);
		end
		return last;
	endfunction : fswdt_pre_last

	////////////////////////////////////////////////////////////////////////////////
	// State.
	////////////////////////////////////////////////////////////////////////////////

	fswdt_pkg::fswdt_state_type     state;          // Present operating state.
	fswdt_pkg::fswdt_state_type     next_state;     // Operating state for the next edge.
	logic [`FSWDT_PRE_WIDTH-1:0]    pre;            // Prescaler count.
	logic [`FSWDT_PRE_WIDTH-1:0]    next_pre;       // Prescaler count for the next edge.
	logic [`FSWDT_CNT_WIDTH-1:0]    next_count;     // Watchdog count for the next edge.
	logic [`FSWDT_CNT_WIDTH-1:0]    reload;         // Programmed reload value.
	logic [`FSWDT_CNT_WIDTH-1:0]    next_reload;    // Reload value for the next edge.
	logic                           sel;            // Prescale select, one for short ratio.
	logic                           next_sel;       // Prescale select for the next edge.
	logic                           next_prewarn;   // Prewarning pulse for the next edge.
	logic                           next_reset;     // Reset request for the next edge.
	logic                           tick;           // Prescaler reaches its last value.

	// A tick falls on the last prescaler value of the selected ratio.
	assign tick        = (pre == fswdt_pre_last(sel));
	// The watchdog counts in the run and warned states only.
	assign wdt_running = (state == fswdt_pkg::FSWDT_RUN) || (state == fswdt_pkg::FSWDT_WARN);

	////////////////////////////////////////////////////////////////////////////////
	// Next-value logic.
	////////////////////////////////////////////////////////////////////////////////

	// Computes every next value; the clocked process below only stores them.
	always_comb begin
		next_state   = state;
		next_pre     = pre;
		next_count   = wdt_count;
		next_reload  = reload;
		next_sel     = sel;
		next_prewarn = 1'b0;
		next_reset   = reset_req;
		// A new reload value takes effect at the next load; a new ratio sets the tick from the next cycle.
		if (reload_write) begin
			next_reload = reload_write_data;
			next_sel    = prescale_write_sel;
		end
		case (state)
			fswdt_pkg::FSWDT_OFF: begin
				// Enable restarts counting from where it stopped.
				if (watchdog_enable_instruction && !watchdog_disable_instruction) begin
					next_state = fswdt_pkg::FSWDT_RUN;
				end
				// A service while stopped still reloads, so a later enable starts fresh.
				if (service_instr) begin
					next_count = reload;
					next_pre   = '0;
				end
			end
			fswdt_pkg::FSWDT_RUN,
			fswdt_pkg::FSWDT_WARN: begin
				if (watchdog_disable_instruction) begin
					// Disable wins over a service or an enable in the same cycle.
					next_state = fswdt_pkg::FSWDT_OFF;
				end else if (service_instr) begin
					// Service also withdraws a pending warned state.
					next_count = reload;
					next_pre   = '0;
					next_state = fswdt_pkg::FSWDT_RUN;
				end else begin
					next_pre = tick ? '0 : pre + 1'b1;
					if (tick) begin
						if (wdt_count == `FSWDT_CNT_TOP) begin
							// Wrap to zero is the overflow; the count restarts at reload.
							next_count = reload;
							if (state == fswdt_pkg::FSWDT_RUN) begin
								next_state   = fswdt_pkg::FSWDT_WARN;
								next_prewarn = 1'b1;
							end else begin
								next_state = fswdt_pkg::FSWDT_FIRED;
								next_reset = 1'b1;
							end
						end else begin
							next_count = wdt_count + 1'b1;
						end
					end
				end
			end
			fswdt_pkg::FSWDT_FIRED: begin
				// The reset request holds until the chip reset arrives.
				next_state = fswdt_pkg::FSWDT_FIRED;
			end
			default: begin
				next_state = fswdt_pkg::FSWDT_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.
	////////////////////////////////////////////////////////////////////////////////

	// Stores the next values; reset needs no software to start the watchdog.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state       <= fswdt_pkg::FSWDT_RUN;
			pre         <= '0;
			wdt_count   <= RELOAD_DEFAULT;
			reload      <= RELOAD_DEFAULT;
			sel         <= `FSWDT_SEL_RESET;
			prewarn_irq <= 1'b0;
			reset_req   <= 1'b0;
		end else begin
			state       <= next_state;
			pre         <= next_pre;
			wdt_count   <= next_count;
			reload      <= next_reload;
			sel         <= next_sel;
			prewarn_irq <= next_prewarn;
			reset_req   <= next_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.
	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	// A counting watchdog that overflows without service or disable.
	sequence seq_overflow;
		wdt_running && !service_instr && !watchdog_disable_instruction
			&& tick && (wdt_count == `FSWDT_CNT_TOP);
	endsequence

	// A service accepted while the watchdog has not fired.
	sequence seq_service;
		service_instr && !watchdog_disable_instruction && (state != fswdt_pkg::FSWDT_FIRED);
	endsequence

	// After release the watchdog is running from the default reload.
	a_reset_starts_run: assert property (
		$past(sys_rst) |-> wdt_running && (wdt_count == RELOAD_DEFAULT)
	) else $error("watchdog not running after reset");

	// Disable stops counting, and the count and prescaler stay put.
	a_disable_stops: assert property (
		wdt_running && watchdog_disable_instruction
			|=> !wdt_running && $stable(wdt_count) && $stable(pre)
	) else $error("disable did not stop the watchdog");

	// Enable from the stopped state restarts counting in the next cycle.
	a_enable_starts: assert property (
		(state == fswdt_pkg::FSWDT_OFF) && watchdog_enable_instruction
			&& !watchdog_disable_instruction |=> wdt_running
	) else $error("enable did not restart the watchdog");

	// First overflow gives a prewarning without reset; a second gives the reset.
	a_overflow_order: assert property (
		((state == fswdt_pkg::FSWDT_RUN) and seq_overflow) |=>
			prewarn_irq && !reset_req && (state == fswdt_pkg::FSWDT_WARN)
	) else $error("overflow did not raise prewarning first");

	// A warned watchdog that overflows again requests reset, with no new prewarning.
	a_second_overflow: assert property (
		((state == fswdt_pkg::FSWDT_WARN) and seq_overflow) |=> reset_req && !prewarn_irq
	) else $error("second overflow did not request reset");

	// A tick advances the count by exactly one.
	a_tick_advance: assert property (
		wdt_running && !service_instr && !watchdog_disable_instruction && tick
			&& (wdt_count != `FSWDT_CNT_TOP) |=> wdt_count == $past(wdt_count) + 1'b1
	) else $error("count did not advance by one on a tick");

	// Between ticks the count holds and the prescaler steps.
	a_no_early_tick: assert property (
		wdt_running && !service_instr && !watchdog_disable_instruction && !tick
			|=> $stable(wdt_count) && (pre == $past(pre) + 1'b1)
	) else $error("count moved without a prescaled tick");

	// A service reloads the count and clears the prescaler together.
	a_service_reload: assert property (
		seq_service |=> (wdt_count == $past(reload)) && (pre == '0)
	) else $error("service did not reload and clear");

	// The default reload and ratio meet the default interval.
	a_default_interval: assert property (
		$past(sys_rst) |-> (reload == RELOAD_DEFAULT) && (sel == `FSWDT_SEL_SHORT)
	) else $error("reset defaults do not give the default interval");

endmodule : fswdt_core

// [fswdt_cpu_model.sv]
`timescale 1ns/1ns

// Core-side partner: issues one-cycle instruction pulses, changed on the falling edge.
module fswdt_cpu_model (
	input  wire logic core_clk,
	output logic      service_instr,
	output logic      watchdog_disable_instruction,
	output logic      watchdog_enable_instruction
);
	// All instruction lines idle low from time zero.
	initial begin
		service_instr = 1'b0;
		watchdog_disable_instruction = 1'b0;
		watchdog_enable_instruction = 1'b0;
	end

	// Executes one instruction: op 0 is service, 1 is disable, 2 is enable.
	task automatic issue(input int op);
		@(negedge core_clk);
		service_instr = (op == 0);
		watchdog_disable_instruction = (op == 1);
		watchdog_enable_instruction = (op == 2);
		@(negedge core_clk);
		service_instr = 1'b0;
		watchdog_disable_instruction = 1'b0;
		watchdog_enable_instruction = 1'b0;
	endtask : issue
endmodule : fswdt_cpu_model

// [fswdt_map.svh]
`ifndef FSWDT_MAP_SVH
`define FSWDT_MAP_SVH

// Prescale ratios of the watchdog tick divider.
`define FSWDT_RATIO_LONG        16384
`define FSWDT_RATIO_SHORT       256
// Width of the prescaler counter, wide enough for the long ratio.
`define FSWDT_PRE_WIDTH         14
// Width of the watchdog counter.
`define FSWDT_CNT_WIDTH         16
// Prescale select encoding: one picks the short ratio.
`define FSWDT_SEL_SHORT         1'b1
`define FSWDT_SEL_RESET         1'b1
// System clock period and the default monitored interval, in nanoseconds.
`define FSWDT_CLK_PERIOD_NS     100
`define FSWDT_INTERVAL_NS       6500000
// Default interval as whole clock cycles.
`define FSWDT_INTERVAL_CYCLES   (`FSWDT_INTERVAL_NS / `FSWDT_CLK_PERIOD_NS)
// Full count of the watchdog counter, one past all ones.
`define FSWDT_CNT_SPAN          65536
// Counter value that overflows on the next tick.
`define FSWDT_CNT_TOP           16'hFFFF

`endif

// [fswdt_pkg.sv]
package fswdt_pkg;

	// Operating states of the watchdog.
	typedef enum logic [1:0] {
		FSWDT_OFF,
		FSWDT_RUN,
		FSWDT_WARN,
		FSWDT_FIRED
	} fswdt_state_type;

endpackage : fswdt_pkg

// [testbench.sv]
`timescale 1ns/1ns
`include "fswdt_map.svh"

module testbench;
	// Expected event: kind 1 is the prewarning pulse, kind 2 the reset request.
	typedef struct {logic [1:0] kind; int due;} fswdt_note_type;
	// A short interval keeps runs brief: reload 16'hFFFC gives four ticks.
	localparam int                         INTERVAL = 1024;
	localparam logic [`FSWDT_CNT_WIDTH-1:0] RST_RELOAD = 16'hFFFC;
	logic                        core_clk, sys_rst, reload_write, prescale_write_sel;
	logic                        service_instr, dis_instr, en_instr, ratio_pick;
	logic                        prewarn_irq, reset_req, wdt_running, old_req;
	logic [`FSWDT_CNT_WIDTH-1:0] reload_write_data, wdt_count, held;
	int                          fail_count = 0, samples_checked = 0, cyc = 0;
	fswdt_note_type              notes[$];

	fswdt_core #(.INTERVAL_CYCLES(INTERVAL)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
		.service_instr(service_instr), .watchdog_disable_instruction(dis_instr),
		.watchdog_enable_instruction(en_instr), .reload_write(reload_write),
		.reload_write_data(reload_write_data), .prescale_write_sel(prescale_write_sel),
		.prewarn_irq(prewarn_irq), .reset_req(reset_req), .wdt_running(wdt_running),
		.wdt_count(wdt_count));
	fswdt_cpu_model cpu (.core_clk(core_clk), .service_instr(service_instr),
		.watchdog_disable_instruction(dis_instr), .watchdog_enable_instruction(en_instr));

	////////////////////////////////////////////////////////////////////////////////
	// Clock of 100 ns and a cycle count used to time events.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// Events get a few cycles of slack, since pipeline latency is not fixed by the rules.
	task automatic cmp_evt(input fswdt_note_type n, input logic [1:0] kind);
		samples_checked++;
		if (kind !== n.kind || cyc - n.due > 4 || n.due - cyc > 4) begin
			fail_count++;
			$display("ERROR t=%0t got=%h_%h exp=%h_%h", $time, kind, cyc, n.kind, n.due);
		end
	endtask : cmp_evt
	task automatic expect_evt(input logic [1:0] kind, input int n);
		notes.push_back('{kind, cyc + n});
	endtask : expect_evt
	// Waits for all noted events; running out of cycles is a failure.
	task automatic drain(input int lim);
		for (int i = 0; i < lim && notes.size() > 0; i++) @(negedge core_clk);
		if (notes.size() > 0) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, notes.size(), 0);
			conclude();
		end
	endtask : drain
	task automatic do_reset();
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (16) @(negedge core_clk);
		sys_rst = 1'b0;
	endtask : do_reset
	task automatic write_reload(input logic [15:0] d, input logic sel);
		@(negedge core_clk);
		reload_write = 1'b1;
		reload_write_data = d;
		prescale_write_sel = sel;
		@(negedge core_clk);
		reload_write = 1'b0;
	endtask : write_reload
	task automatic conclude();
		$display("checks=%0d errors=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////////
	// Watcher: any event with nothing noted is itself a mismatch.
	always @(posedge core_clk) begin
		#1;
		if (prewarn_irq === 1'b1 || (reset_req === 1'b1 && old_req !== 1'b1)) begin
			if (notes.size() == 0) cmp({14'h0000, reset_req, prewarn_irq}, 16'h0000);
			else cmp_evt(notes.pop_front(), prewarn_irq ? 2'h1 : 2'h2);
		end
		old_req = reset_req;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		reload_write = 1'b0;
		reload_write_data = 16'h0000;
		prescale_write_sel = 1'b0;
		void'($urandom(32'h5d6d_10ee));
		do_reset();
		// Unserviced after reset: prewarning after four ticks, reset request four later.
		cmp({15'h0000, wdt_running}, 16'h0001);
		cmp(wdt_count, RST_RELOAD);
		expect_evt(2'h1, 1024);
		expect_evt(2'h2, 2048);
		drain(2300);
		do_reset();
		// Service mid-tick: count reloads and the prescaler restarts from zero.
		repeat (700) @(negedge core_clk);
		cpu.issue(0);
		cmp(wdt_count, RST_RELOAD);
		expect_evt(2'h1, 1024);
		repeat (200) @(negedge core_clk);
		cmp(wdt_count, RST_RELOAD);
		drain(1100);
		// Service while warned returns to plain running, so the next overflow warns again.
		cpu.issue(0);
		expect_evt(2'h1, 1024);
		drain(1100);
		// Disable freezes the count; enable resumes and forgets the warning.
		cpu.issue(1);
		held = wdt_count;
		cmp({15'h0000, wdt_running}, 16'h0000);
		repeat (3000) @(negedge core_clk);
		cmp(wdt_count, held);
		cpu.issue(2);
		cmp({15'h0000, wdt_running}, 16'h0001);
		// The prescaler froze at one, so one cycle of the interval is already spent.
		expect_evt(2'h1, 1024 - 1);
		drain(1100);
		// Random ratio: a random short reload, or one long tick to keep the run brief.
		ratio_pick = 1'($urandom);
		held = ratio_pick ? (16'hFFF8 | (16'($urandom) & 16'h0007)) : 16'hFFFF;
		write_reload(held, ratio_pick);
		cpu.issue(0);
		cmp(wdt_count, held);
		expect_evt(2'h1, (65536 - int'(held))
			* (ratio_pick ? `FSWDT_RATIO_SHORT : `FSWDT_RATIO_LONG));
		drain(17000);
		write_reload(16'hFFFF, 1'b0);
		cpu.issue(0);
		expect_evt(2'h1, 16384);
		expect_evt(2'h2, 32768);
		drain(34000);
		conclude();
	end
endmodule : testbench
